/* verilog/lner_defines.vh */
// Overview of operation
// - A rejected message is answered by a negative acknowledge carrying a two-character ASCII hex code 00H..FFH.
// - When several faults are found in one message only the numerically lowest code is reported.
// - Every fault that yields a negative acknowledge returns the whole transfer sequence to its initial state.
// - Code 02H is reported when the received checksum differs from the one computed over the message.
// - Code 03H is reported for a wrong or partly wrong control procedure or an undefined command.
// - Code 06H is reported for character area faults such as a missing device or a device number not 5 or 7 characters long.
// - Code 07H is reported when write data characters are not hexadecimal digits.
// - Code 0AH or 10H is reported when the addressed controller number has no station.
// - Code 18H is reported when remote run or stop is requested while the mode is fixed by hardware.
// - Receive and transmit indicators flash during traffic in their direction and for HOLD_CYC clocks after it, then stay dark.
`ifndef LNER_DEFINES_VH
`define LNER_DEFINES_VH
`define LNER_ERR_SUM 8'h02
`define LNER_ERR_PROTO 8'h03
`define LNER_ERR_CHAR_AREA 8'h06
`define LNER_ERR_CHAR 8'h07
`define LNER_ERR_CTRL_A 8'h0A
`define LNER_ERR_CTRL_B 8'h10
`define LNER_ERR_REMOTE 8'h18
`define LNER_ASCII_NAK 8'h15
`define LNER_CTRL_NUM 8'hFF
`define LNER_FRAME_LEN 3'h7
`define LNER_FLASH_NS 50000000
`define LNER_CLK_NS 100
`define LNER_FLASH_CYC (`LNER_FLASH_NS / `LNER_CLK_NS)
`define LNER_HOLD_CYC 5000000
`endif

/* verilog/lner_indicator.v */
`timescale 1ns/100ps
`include "lner_defines.vh"
module lner_indicator #(
  parameter FLASH_CYC = `LNER_FLASH_CYC,
  parameter HOLD_CYC = `LNER_HOLD_CYC
) (
  core_clk,
  arst_n,
  activity,
  led
);
  input wire core_clk;
  input wire arst_n;
  input wire activity;
  output reg led;
  reg [31:0] hold_q;
  reg [31:0] half_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 32'h0;
      half_q <= 32'h0;
      led <= 1'b0;
    end else begin
      if (activity) begin
        hold_q <= HOLD_CYC;
      end else if (hold_q != 32'h0) begin
        hold_q <= hold_q - 32'h1;
      end
      if (hold_q == 32'h0 && !activity) begin
        half_q <= 32'h0;
        led <= 1'b0;
      end else if (half_q == 32'h0) begin
        half_q <= FLASH_CYC / 2 - 1;
        led <= ~led;
      end else begin
        half_q <= half_q - 32'h1;
      end
    end
  end
endmodule

/* verilog/lner_nak_responder.v */
`timescale 1ns/100ps
`include "lner_defines.vh"
module lner_nak_responder #(
  parameter FLASH_CYC = `LNER_FLASH_CYC,
  parameter HOLD_CYC = `LNER_HOLD_CYC
) (
  core_clk,
  arst_n,
  msg_done,
  station_num,
  ctrl_num,
  sum_bad,
  proto_bad,
  char_area_bad,
  char_bad,
  ctrl_bad,
  ctrl_bad_alt,
  remote_locked,
  rx_char_strobe,
  tx_ready,
  tx_valid,
  tx_data,
  nak_busy,
  seq_init,
  err_code,
  receive_activity_indicator,
  transmit_activity_indicator
);
  input wire core_clk;
  input wire arst_n;
  input wire msg_done;
  input wire [7:0] station_num;
  input wire [7:0] ctrl_num;
  input wire sum_bad;
  input wire proto_bad;
  input wire char_area_bad;
  input wire char_bad;
  input wire ctrl_bad;
  input wire ctrl_bad_alt;
  input wire remote_locked;
  input wire rx_char_strobe;
  input wire tx_ready;
  output reg tx_valid;
  output reg [7:0] tx_data;
  output reg nak_busy;
  output reg seq_init;
  output reg [7:0] err_code;
  output wire receive_activity_indicator;
  output wire transmit_activity_indicator;

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg state_q;
  reg [2:0] idx_q;
  reg [7:0] code_q;
  reg [7:0] stn_q;
  reg [7:0] ctl_q;
  reg any_err;
  reg [7:0] code_d;
  reg [7:0] char_d;
  reg tx_pulse_q;

  function [7:0] hex_ascii;
    input [3:0] nib;
    begin
      if (nib < 4'hA) begin
        hex_ascii = 8'h30 + {4'h0, nib};
      end else begin
        hex_ascii = 8'h37 + {4'h0, nib};
      end
    end
  endfunction

  // Lowest code wins when several faults coincide.
  always @* begin
    any_err = 1'b1;
    code_d = 8'h00;
    if (sum_bad) begin
      code_d = `LNER_ERR_SUM;
    end else if (proto_bad) begin
      code_d = `LNER_ERR_PROTO;
    end else if (char_area_bad) begin
      code_d = `LNER_ERR_CHAR_AREA;
    end else if (char_bad) begin
      code_d = `LNER_ERR_CHAR;
    end else if (ctrl_bad) begin
      code_d = `LNER_ERR_CTRL_A;
    end else if (ctrl_bad_alt) begin
      code_d = `LNER_ERR_CTRL_B;
    end else if (remote_locked) begin
      code_d = `LNER_ERR_REMOTE;
    end else begin
      any_err = 1'b0;
    end
  end

  // Frame characters in order of transmission.
  always @* begin
    case (idx_q)
      3'h0: char_d = `LNER_ASCII_NAK;
      3'h1: char_d = hex_ascii(stn_q[7:4]);
      3'h2: char_d = hex_ascii(stn_q[3:0]);
      3'h3: char_d = hex_ascii(ctl_q[7:4]);
      3'h4: char_d = hex_ascii(ctl_q[3:0]);
      3'h5: char_d = hex_ascii(code_q[7:4]);
      3'h6: char_d = hex_ascii(code_q[3:0]);
      default: char_d = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      idx_q <= 3'h0;
      code_q <= 8'h00;
      stn_q <= 8'h00;
      ctl_q <= 8'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      nak_busy <= 1'b0;
      seq_init <= 1'b0;
      err_code <= 8'h00;
      tx_pulse_q <= 1'b0;
    end else begin
      seq_init <= 1'b0;
      tx_pulse_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (msg_done && any_err) begin
            state_q <= ST_SEND;
            code_q <= code_d;
            err_code <= code_d;
            stn_q <= station_num;
            ctl_q <= ctrl_num;
            idx_q <= 3'h0;
            nak_busy <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
            tx_pulse_q <= 1'b1;
            if (idx_q == `LNER_FRAME_LEN - 3'h1) begin
              state_q <= ST_IDLE;
              nak_busy <= 1'b0;
              seq_init <= 1'b1;
            end
            idx_q <= idx_q + 3'h1;
          end else if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data <= char_d;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  lner_indicator #(.FLASH_CYC(FLASH_CYC), .HOLD_CYC(HOLD_CYC)) u_rx_led (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .activity(rx_char_strobe),
    .led(receive_activity_indicator)
  );

  lner_indicator #(.FLASH_CYC(FLASH_CYC), .HOLD_CYC(HOLD_CYC)) u_tx_led (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .activity(tx_pulse_q),
    .led(transmit_activity_indicator)
  );
endmodule

/* tb/lner_chk.sv */
`timescale 1ns/100ps
module lner_chk (
  input wire core_clk,
  input wire arst_n,
  input wire msg_done,
  input wire sum_bad,
  input wire proto_bad,
  input wire tx_ready,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire nak_busy,
  input wire seq_init,
  input wire [7:0] err_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_sum; msg_done && sum_bad && !nak_busy |=> nak_busy && err_code == 8'h02; endproperty
  a_sum: assert property (p_sum) else $error("bad code 02");
  property p_low; msg_done && proto_bad && !sum_bad && !nak_busy |=> err_code == 8'h03; endproperty
  a_low: assert property (p_low) else $error("bad code 03");
  property p_nak; $rose(nak_busy) |=> tx_valid && tx_data == 8'h15; endproperty
  a_nak: assert property (p_nak) else $error("no lead char");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("char not held");
  property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_pulse; seq_init |=> !seq_init; endproperty
  a_pulse: assert property (p_pulse) else $error("long init");
  property p_idle; !nak_busy |-> !tx_valid; endproperty
  a_idle: assert property (p_idle) else $error("send when idle");
  property p_drop; nak_busy && msg_done |=> $stable(err_code); endproperty
  a_drop: assert property (p_drop) else $error("busy capture");
endmodule
bind lner_nak_responder lner_chk u_chk (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .msg_done(msg_done),
  .sum_bad(sum_bad),
  .proto_bad(proto_bad),
  .tx_ready(tx_ready),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .nak_busy(nak_busy),
  .seq_init(seq_init),
  .err_code(err_code)
);

/* tb/lner_host.sv */
`timescale 1ns/100ps
module lner_host (
  input wire core_clk,
  input wire slow,
  output logic tx_ready = 1'b0
);
  logic [1:0] cnt_q = 2'h0;
  // Takes characters at once, or on one edge in four when slow.
  always @(negedge core_clk) begin
    cnt_q <= cnt_q + 2'h1;
    tx_ready <= !slow || cnt_q == 2'h3;
  end
endmodule

/* tb/lner_nak_responder_tb.sv */
`timescale 1ns/100ps
module lner_nak_responder_tb;
  logic core_clk = 0, arst_n = 0, msg_done = 0, rx_char_strobe = 0, slow = 0;
  logic tx_ready, tx_valid, nak_busy, seq_init, rx_ind, tx_ind, rx_lit = 0, tx_lit = 0;
  logic [6:0] flt = 7'h00;
  logic [7:0] st = 8'h00, tx_data, err_code, e[7], got[$];
  logic [14:0] rows[10] = '{15'h0102, 15'h0203, 15'h0406, 15'h0807, 15'h100A,
    15'h2010, 15'h4018, 15'h7E03, 15'h6010, 15'h7F02};
  int errors = 0, tests_run = 0, inits = 0;
  always #50 core_clk = ~core_clk;
  lner_nak_responder #(.FLASH_CYC(4), .HOLD_CYC(20)) u_dut (.core_clk(core_clk),
    .arst_n(arst_n), .msg_done(msg_done), .station_num(st), .ctrl_num(8'hFF),
    .sum_bad(flt[0]), .proto_bad(flt[1]), .char_area_bad(flt[2]), .char_bad(flt[3]),
    .ctrl_bad(flt[4]), .ctrl_bad_alt(flt[5]), .remote_locked(flt[6]),
    .rx_char_strobe(rx_char_strobe), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .nak_busy(nak_busy), .seq_init(seq_init), .err_code(err_code),
    .receive_activity_indicator(rx_ind), .transmit_activity_indicator(tx_ind));
  lner_host u_host (.core_clk(core_clk), .slow(slow), .tx_ready(tx_ready));
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (seq_init) inits <= inits + 1;
    rx_lit <= rx_lit | rx_ind;
    tx_lit <= tx_lit | tx_ind;
  end
  function automatic [7:0] asc(input [3:0] n);
    return n < 4'hA ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic chk(input string what, input [7:0] exp, input [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic send(input [14:0] r);
    int n;
    flt = r[14:8];
    msg_done = 1;
    rx_char_strobe = 1;
    @(negedge core_clk) msg_done = 0;
    rx_char_strobe = 0;
    repeat (2) @(negedge core_clk);
    chk("nak_busy", 8'h01, {7'h00, nak_busy});
    msg_done = 1;
    flt = 7'h7F;
    @(negedge core_clk) msg_done = 0;
    flt = 7'h00;
    e = '{8'h15, asc(st[7:4]), asc(st[3:0]), 8'h46, 8'h46, asc(r[7:4]), asc(r[3:0])};
    n = 0;
    while (got.size() < 7 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    chk("err_code", r[7:0], err_code);
    chk("count", 8'h07, 8'(got.size()));
    for (int i = 0; i < 7; i++) chk("frame", e[i], got[i]);
    got = {};
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    arst_n = 1;
    foreach (rows[i]) begin
      st = 8'(i * 29);
      slow = i[0];
      send(rows[i]);
    end
    flt = 7'h01;
    msg_done = 1;
    @(negedge core_clk) msg_done = 0;
    flt = 7'h00;
    repeat (3) @(negedge core_clk);
    arst_n = 0;
    @(negedge core_clk);
    chk("reset", 8'h00, {3'h0, tx_valid, nak_busy, seq_init, rx_ind, tx_ind});
    chk("reset_code", 8'h00, err_code);
    arst_n = 1;
    got = {};
    send(rows[9]);
    msg_done = 1;
    @(negedge core_clk) msg_done = 0;
    repeat (60) @(negedge core_clk);
    chk("extra", 8'h00, 8'(got.size()));
    chk("seq_init", 8'h0B, 8'(inits));
    chk("idle", 8'h00, {6'h00, nak_busy, tx_valid});
    chk("lit", 8'h03, {6'h00, rx_lit, tx_lit});
    chk("dark", 8'h00, {6'h00, rx_ind, tx_ind});
    end_sim;
  end
  initial begin
    #300000;
    errors++;
    end_sim;
  end
endmodule
